// >>> dv/acd_core_sva.sv
// concurrent checks on the datapath ports
`timescale 1ns/10ps
module acd_core_chk
	import acd_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic              instr_valid,
	input wire logic [15:0]       instr,
	input wire logic              busy_q,
	input wire logic              done_q,
	input wire logic              cond_flag_q,
	input wire logic              div_q_q,
	input wire logic              div_m_q,
	input wire acd_pkg::acd_mac_s mac_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic took_q; // a request was accepted last edge
	logic take;   // a request is accepted at this edge
	logic mul;    // the request is a multiply
	assign take = instr_valid && !busy_q && !took_q;
	assign mul = (instr[15:12] == 4'h3) && (instr[3:0] == 4'hD);
	// remembers acceptance so the following edge is refused
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			took_q <= 1'b0;
		else
			took_q <= take;
	end
	a_single_done_time: assert property (take && !mul |-> ##2 done_q ##1 !done_q)
		else $error("single cycle op completed at wrong time");
	a_mul_done_time: assert property (take && mul |-> ##5 done_q ##1 !done_q)
		else $error("multiply completed at wrong time");
	a_single_busy_one: assert property (take && !mul |=> busy_q ##1 !busy_q)
		else $error("busy length wrong for single op");
	a_mul_busy_hold: assert property (take && mul |=> busy_q [*4] ##1 !busy_q)
		else $error("busy dropped early during multiply");
	a_flag_only_done: assert property ($changed(cond_flag_q) |-> done_q)
		else $error("flag moved without completion");
	a_mac_only_done: assert property ($changed(mac_q) |-> done_q)
		else $error("accumulator moved without completion");
	a_div_bits_done: assert property ($changed({div_q_q, div_m_q}) |-> done_q)
		else $error("sign bits moved without completion");
	a_add_keeps_flag: assert property (take && instr[15:12] == 4'h3 && instr[3:0] == 4'hC |-> ##2 $stable(cond_flag_q))
		else $error("register add changed the flag");
	a_div_flag_xor: assert property (take && instr[15:12] == 4'h2 && instr[3:0] == 4'h7 |-> ##2 cond_flag_q == (div_q_q ^ div_m_q))
		else $error("division setup flag is not the sign xor");
endmodule // acd_core_chk

bind acd_core acd_core_chk u_chk (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr), .busy_q(busy_q),
	.done_q(done_q), .cond_flag_q(cond_flag_q), .div_q_q(div_q_q), .div_m_q(div_m_q), .mac_q(mac_q));

// >>> dv/acd_core_tb_top.sv
// self-checking bench of the arithmetic and compare datapath
`timescale 1ns/10ps
module acd_core_tb_top;
	import acd_pkg::*;
	localparam int D = 5;         // drive delay after the edge
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic instr_valid = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [3:0] dbg_idx = 4'h0;
	logic busy_q, done_q, cond_flag_q, div_q_q, div_m_q;
	acd_mac_s mac_q;
	logic [31:0] dbg_data_q;
	logic [31:0] rg [16];         // expected registers
	logic tf, mq, mm;             // expected flag and sign bits
	logic [63:0] mx;              // expected product
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	always #25 clk = ~clk;
	acd_core uut (.clk(clk), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr), .dbg_idx(dbg_idx),
		.busy_q(busy_q), .done_q(done_q), .cond_flag_q(cond_flag_q), .div_q_q(div_q_q), .div_m_q(div_m_q),
		.mac_q(mac_q), .dbg_data_q(dbg_data_q));
	// cuts a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test;
	begin
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
	begin
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	end
	endtask
	function automatic logic [31:0] sx(input logic [7:0] i);
		return {{24{i[7]}}, i};
	endfunction
	// expected effect of one instruction word
	task automatic model(input logic [15:0] w);
		logic [31:0] a, b, s;
		logic [32:0] c;
	begin
		a = rg[w[11:8]];
		b = rg[w[7:4]];
		c = {1'b0, a} + {1'b0, b};
		s = c[31:0];
		casez (w)
			16'h3??C: rg[w[11:8]] = s;
			16'h3??E: {tf, rg[w[11:8]]} = c + 33'(tf);
			16'h3??F: {tf, rg[w[11:8]]} = {(a[31] == b[31]) && (s[31] != a[31]), s};
			16'h7???: rg[w[11:8]] = a + sx(w[7:0]);
			16'h88??: tf = (rg[0] == sx(w[7:0]));
			16'h3??0: tf = (a == b);
			16'h3??2: tf = (a >= b);
			16'h3??3: tf = ($signed(a) >= $signed(b));
			16'h3??6: tf = (a > b);
			16'h3??7: tf = ($signed(a) > $signed(b));
			16'h4?11: tf = !a[31];
			16'h4?15: tf = ($signed(a) > 0);
			16'h2??C: tf = (a[7:0] == b[7:0]) || (a[15:8] == b[15:8]) || (a[23:16] == b[23:16]) || (a[31:24] == b[31:24]);
			16'h2??7: {mq, mm, tf} = {a[31], b[31], a[31] ^ b[31]};
			16'h3??D: mx = $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
			default: ;
		endcase
	end
	endtask
	// issues one word held for hold edges, then judges every result
	task automatic run(input logic [15:0] w, input int hold);
		int n;
	begin
		model(w);
		instr = w;
		instr_valid = 1'b1;
		repeat (hold) @(posedge clk);
		#D instr_valid = 1'b0;
		n = hold - 1;
		while (done_q !== 1'b1 && n < 12)
		begin
			@(posedge clk);
			#D n++;
		end
		check("latency", n, (w[15:12] == 4'h3 && w[3:0] == 4'hD) ? 4 : 1);
		check("flag", cond_flag_q, tf);
		check("sign bits", {div_q_q, div_m_q}, {mq, mm});
		check("mac", mac_q, mx);
		dbg_idx = w[11:8];
		repeat (3) @(posedge clk);
		#D check("dest", dbg_data_q, rg[w[11:8]]);
	end
	endtask
	// builds extremes by adding, wrapping past the top
	task automatic t_add;
	begin
		run(16'h71FF, 1);
		run(16'h7201, 1);
		repeat (31) run(16'h322C, 1);
		run(16'h332C, 1);
		run(16'h331C, 1);
	end
	endtask
	task automatic t_carry;
	begin
		run(16'h3110, 1);
		run(16'h351E, 1);
		run(16'h355E, 1);
		run(16'h363C, 1);
		run(16'h366F, 1);
		run(16'h361F, 1);
		run(16'h372C, 1);
		run(16'h377F, 1);
	end
	endtask
	// every register compare against equal, sign-crossing and ordered pairs
	task automatic t_cmp;
		logic [7:0] ops [7] = '{8'h30, 8'h32, 8'h33, 8'h36, 8'h37, 8'h2C, 8'h27};
		logic [7:0] prs [5] = '{8'h11, 8'h13, 8'h31, 8'h23, 8'h32};
	begin
		foreach (ops[i])
			foreach (prs[j])
				run({ops[i][7:4], prs[j], ops[i][3:0]}, 1);
		for (int i = 0; i < 4; i++)
		begin
			run({4'h4, 4'(i), 8'h11}, 1);
			run({4'h4, 4'(i), 8'h15}, 1);
		end
	end
	endtask
	task automatic t_imm;
	begin
		run(16'h8800, 1);
		run(16'h8801, 1);
		run(16'h70FF, 1);
		run(16'h88FF, 1);
	end
	endtask
	task automatic t_mul;
	begin
		run(16'h312D, 1);
		run(16'h333D, 1);
		run(16'h323D, 1);
	end
	endtask
	// held request taken once, unknown word leaves everything alone
	task automatic t_refuse;
	begin
		run(16'h7901, 2);
		run(16'hF123, 1);
	end
	endtask
	task automatic t_all;
	begin
		for (int i = 0; i < 16; i++)
		begin
			dbg_idx = 4'(i);
			repeat (3) @(posedge clk);
			#D check("reg", dbg_data_q, rg[i]);
		end
	end
	endtask
	initial
	begin
		foreach (rg[i])
			rg[i] = 32'h00000000;
		{tf, mq, mm, mx} = '0;
		repeat (3) @(posedge clk);
		#D rst_b = 1'b1;
		t_add();
		t_carry();
		t_cmp();
		t_imm();
		t_mul();
		t_refuse();
		t_all();
		stop_test();
	end
endmodule // acd_core_tb_top

// >>> hdl/acd_core.sv
// arithmetic and compare datapath: decode, execute, flags and multiply
// Notes on behaviour
// - register add writes destination, flag kept
// - immediate add to destination, one cycle
// - add with carry, carry out to flag
// - checked add, signed overflow to flag
// - register zero equals immediate sets flag
// - register equality sets flag
// - unsigned greater or equal sets flag
// - signed greater or equal sets flag
// - unsigned strictly greater sets flag
// - signed strictly greater sets flag
// - register nonnegative sets flag
// - register strictly positive sets flag
// - any matching byte lane sets flag
// - division setup copies signs, xor to flag
// - signed 64-bit product into accumulator pair
`timescale 1ns/10ps
`include "acd_params.svh"

module acd_core
	import acd_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                rst_b,
	input  wire logic                instr_valid,
	input  wire logic [15:0]         instr,
	input  wire logic [3:0]          dbg_idx,
	output logic                     busy_q,
	output logic                     done_q,
	output logic                     cond_flag_q,
	output logic                     div_q_q,
	output logic                     div_m_q,
	output acd_pkg::acd_mac_s        mac_q,
	output logic [31:0]              dbg_data_q
);
	import acd_pkg::*;

	// operand fetch stage: indexes captured with the instruction
	logic        ex_valid_q;    // instruction in execute, operands read
	logic [15:0] ex_instr_q;    // instruction in execute
	logic [31:0] rn_val;        // destination operand
	logic [31:0] rm_val;        // source operand
	logic [31:0] r0_val;        // register zero
	acd_op_e     op;            // decoded operation
	acd_wr_s     wr;            // register file write
	acd_mst_e    mst_q;         // multiplier state
	logic [2:0]  mcnt_q;        // multiplier cycle counter
	logic [31:0] mul_a_q;       // latched multiplicand
	logic [31:0] mul_b_q;       // latched multiplier
	// execute stage nets, all combinational from the operand, instruction and flag registers
	logic [31:0] imm_ext;       // sign extended immediate
	logic [32:0] sum_c;         // sum with carry out
	logic [31:0] sum_p;         // plain sum
	logic        ovf;           // signed overflow of plain sum
	logic        any_byte;      // some lane equal
	logic [63:0] prod;          // full signed product
	// take stage nets, decoded from the incoming word, the handshake and the debug index
	logic [3:0]  rn_idx;        // destination field
	logic [3:0]  rm_idx;        // source field
	logic [3:0]  rd_a_sel;      // read port a select
	logic        accept;        // new instruction taken

	assign rn_idx = instr[`ACD_RN_MSB:`ACD_RN_LSB];
	assign rm_idx = instr[`ACD_RM_MSB:`ACD_RM_LSB];
	assign accept = instr_valid && !busy_q && !ex_valid_q;
	// read port a serves the destination on a take, or the debug view in every other cycle;
	// the debug view therefore stalls for the cycle an instruction is taken
	assign rd_a_sel = accept ? rn_idx : dbg_idx;

	// register file: forwarding makes a write visible to a read in the same edge
	acd_regfile u_rf
	(
		.clk      (clk),
		.rst_b    (rst_b),
		.rd_a_idx (rd_a_sel),
		.rd_b_idx (rm_idx),
		.wr       (wr),
		.rd_a_q   (rn_val),
		.rd_b_q   (rm_val),
		.r0_q     (r0_val)
	);

	// capture instruction for execute the cycle after operands are read
	// operands come out of registered read ports, so execute lags the
	// take by one edge; a second take in that edge would lose its operands
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ex_valid_q <= 1'b0;
			ex_instr_q <= 16'h0000;
		end
		else
		begin
			ex_valid_q <= accept;
			if (accept)
				ex_instr_q <= instr;
		end
	end

	// decode of the instruction in execute
	// unlisted words decode as reserved and retire with no effect
	always_comb
	begin
		op = ACD_OP_NONE;
		if (!ex_valid_q)
			op = ACD_OP_NONE;
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_0011)
		begin
			case (ex_instr_q[`ACD_NIB_LO_MSB:`ACD_NIB_LO_LSB])
				`ACD_LO_ADD:  op = ACD_OP_ADD;
				`ACD_LO_ADD_CARRY: op = ACD_OP_ADD_CARRY;
				`ACD_LO_ADD_OVF:   op = ACD_OP_ADD_OVF;
				`ACD_LO_EQ:   op = ACD_OP_EQ;
				`ACD_LO_HS:   op = ACD_OP_HS;
				`ACD_LO_GE:   op = ACD_OP_GE;
				`ACD_LO_HI:   op = ACD_OP_HI;
				`ACD_LO_GT:   op = ACD_OP_GT;
				`ACD_LO_MUL:  op = ACD_OP_MUL;
				default:      op = ACD_OP_RSV;
			endcase
		end
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_0111)
			op = ACD_OP_ADDI;
		// immediate compare needs the fixed second nibble as well
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_1000
			&& ex_instr_q[`ACD_RN_MSB:`ACD_RN_LSB] == `ACD_CMPIMM_SUB)
			op = ACD_OP_EQI;
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_0100
			&& ex_instr_q[`ACD_BYTE_MSB:`ACD_BYTE_LSB] == `ACD_LB_PZ)
			op = ACD_OP_PZ;
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_0100
			&& ex_instr_q[`ACD_BYTE_MSB:`ACD_BYTE_LSB] == `ACD_LB_PL)
			op = ACD_OP_PL;
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_0010
			&& ex_instr_q[`ACD_NIB_LO_MSB:`ACD_NIB_LO_LSB] == `ACD_LO_STR)
			op = ACD_OP_STR;
		else if (ex_instr_q[`ACD_NIB_HI_MSB:`ACD_NIB_HI_LSB] == `ACD_HI_0010
			&& ex_instr_q[`ACD_NIB_LO_MSB:`ACD_NIB_LO_LSB] == `ACD_LO_DIVS)
			op = ACD_OP_DIVS;
		else
			op = ACD_OP_RSV;
	end

	// shared arithmetic
	// one 33-bit adder serves every add; its top bit is the carry out
	// and the low word wraps on its own
	assign imm_ext = {{24{ex_instr_q[`ACD_BYTE_MSB]}}, ex_instr_q[`ACD_BYTE_MSB:`ACD_BYTE_LSB]};
	assign sum_c = (op == ACD_OP_ADD_CARRY)
		? {1'b0, rn_val} + {1'b0, rm_val} + {32'h00000000, cond_flag_q}
		: {1'b0, rn_val} + {1'b0, (op == ACD_OP_ADDI) ? imm_ext : rm_val};
	assign sum_p = sum_c[31:0];
	// overflow: both operands share a sign that the sum does not
	assign ovf = (rn_val[31] == rm_val[31]) && (sum_p[31] != rn_val[31]);
	// byte lanes compared in parallel, any single hit is enough
	assign any_byte = (rn_val[31:24] == rm_val[31:24]) || (rn_val[23:16] == rm_val[23:16])
		|| (rn_val[15:8] == rm_val[15:8]) || (rn_val[7:0] == rm_val[7:0]);

	// register write back; compares never write
	// index and data are driven every cycle, only the enable qualifies them,
	// so the write port carries no extra mux ahead of the storage
	always_comb
	begin
		wr.en   = 1'b0;
		wr.idx  = ex_instr_q[`ACD_RN_MSB:`ACD_RN_LSB];
		wr.data = sum_p;
		case (op)
			ACD_OP_ADD:  wr.en = 1'b1;
			ACD_OP_ADDI: wr.en = 1'b1;
			ACD_OP_ADD_CARRY: wr.en = 1'b1;
			ACD_OP_ADD_OVF:   wr.en = 1'b1;
			default:     wr.en = 1'b0;
		endcase
	end

	// condition flag update
	// every compare writes the flag, true or false; plain adds and
	// reserved words keep it as it stands
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			cond_flag_q <= 1'b0;
		else
		begin
			case (op)
				ACD_OP_ADD_CARRY: cond_flag_q <= sum_c[32];
				ACD_OP_ADD_OVF:   cond_flag_q <= ovf;
				ACD_OP_EQI:  cond_flag_q <= (r0_val == imm_ext);
				ACD_OP_EQ:   cond_flag_q <= (rn_val == rm_val);
				ACD_OP_HS:   cond_flag_q <= (rn_val >= rm_val);
				ACD_OP_GE:   cond_flag_q <= ($signed(rn_val) >= $signed(rm_val));
				ACD_OP_HI:   cond_flag_q <= (rn_val > rm_val);
				ACD_OP_GT:   cond_flag_q <= ($signed(rn_val) > $signed(rm_val));
				ACD_OP_PZ:   cond_flag_q <= !rn_val[31];
				ACD_OP_PL:   cond_flag_q <= !rn_val[31] && (rn_val != `ACD_ZERO32);
				ACD_OP_STR:  cond_flag_q <= any_byte;
				ACD_OP_DIVS: cond_flag_q <= rn_val[31] ^ rm_val[31];
				default:     cond_flag_q <= cond_flag_q;
			endcase
		end
	end

	// division sign bits
	// only the setup step touches them; they hold for the later steps
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			div_q_q <= 1'b0;
			div_m_q <= 1'b0;
		end
		else if (op == ACD_OP_DIVS)
		begin
			div_q_q <= rn_val[31];
			div_m_q <= rm_val[31];
		end
	end

	// multiplier sequencer: latch operands, hold busy for the product latency
	// operands are latched at execute because the read ports move on to
	// the debug view; the product settles over the counted cycles and
	// is taken only on the last one
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mst_q   <= ACD_MS_IDLE;
			mcnt_q  <= 3'h0;
			mul_a_q <= `ACD_ZERO32;
			mul_b_q <= `ACD_ZERO32;
		end
		else
		begin
			case (mst_q)
				ACD_MS_IDLE:
				begin
					if (op == ACD_OP_MUL)
					begin
						mst_q   <= ACD_MS_BUSY;
						mcnt_q  <= `ACD_MUL_CYCLES;
						mul_a_q <= rn_val;
						mul_b_q <= rm_val;
					end
				end
				ACD_MS_BUSY:
				begin
					if (mcnt_q == 3'h1)
						mst_q <= ACD_MS_IDLE;
					mcnt_q <= mcnt_q - 3'h1;
				end
				default:
					mst_q <= ACD_MS_IDLE;
			endcase
		end
	end

	// both factors signed, so the 64-bit context extends them by sign
	assign prod = $signed(mul_a_q) * $signed(mul_b_q);

	// accumulator pair written on the last multiplier cycle
	// high half takes the upper product word, low half the lower
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			mac_q <= `ACD_ZERO64;
		else if (mst_q == ACD_MS_BUSY && mcnt_q == 3'h1)
		begin
			mac_q.high <= prod[63:32];
			mac_q.low  <= prod[31:0];
		end
	end

	// handshake outputs: busy while any instruction is in flight
	// busy covers the execute edge so a held request is not taken twice;
	// done marks the edge after which results are visible
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else
		begin
			busy_q <= accept || (op == ACD_OP_MUL)
				|| (mst_q == ACD_MS_BUSY && mcnt_q != 3'h1);
			done_q <= (ex_valid_q && op != ACD_OP_MUL)
				|| (mst_q == ACD_MS_BUSY && mcnt_q == 3'h1);
		end
	end

	// registered view of one general register
	// two edges behind the index, stale while an instruction is taken
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			dbg_data_q <= `ACD_ZERO32;
		else
			dbg_data_q <= rn_val;
	end
endmodule // acd_core

// >>> hdl/acd_params.svh
// timing, field and encoding constants of the arithmetic and compare datapath
`ifndef ACD_PARAMS_SVH
`define ACD_PARAMS_SVH

`define ACD_CLK_PERIOD_NS 50
`define ACD_MUL_CYCLES    3'h3
`define ACD_NIB_HI_MSB    15
`define ACD_NIB_HI_LSB    12
`define ACD_RN_MSB        11
`define ACD_RN_LSB        8
`define ACD_RM_MSB        7
`define ACD_RM_LSB        4
`define ACD_NIB_LO_MSB    3
`define ACD_NIB_LO_LSB    0
`define ACD_BYTE_MSB      7
`define ACD_BYTE_LSB      0
`define ACD_HI_0010       4'h2
`define ACD_HI_0011       4'h3
`define ACD_HI_0100       4'h4
`define ACD_HI_0111       4'h7
`define ACD_HI_1000       4'h8
`define ACD_CMPIMM_SUB    4'h8
`define ACD_LO_ADD        4'hC
`define ACD_LO_ADD_CARRY  4'hE
`define ACD_LO_ADD_OVF    4'hF
`define ACD_LO_EQ         4'h0
`define ACD_LO_HS         4'h2
`define ACD_LO_GE         4'h3
`define ACD_LO_HI         4'h6
`define ACD_LO_GT         4'h7
`define ACD_LO_MUL        4'hD
`define ACD_LO_STR        4'hC
`define ACD_LO_DIVS       4'h7
`define ACD_LB_PZ         8'h11
`define ACD_LB_PL         8'h15
`define ACD_R0            4'h0
`define ACD_ZERO32        32'h00000000
`define ACD_ZERO64        64'h0000000000000000

`endif

// >>> hdl/acd_pkg.sv
// types shared by the arithmetic and compare datapath
package acd_pkg;

	// register file write request
	typedef struct packed
	{
		logic        en;
		logic [3:0]  idx;
		logic [31:0] data;
	} acd_wr_s;

	// multiply accumulate pair
	typedef struct packed
	{
		logic [31:0] high;
		logic [31:0] low;
	} acd_mac_s;

	// decoded operation
	typedef enum logic [16:0]
	{
		ACD_OP_NONE  = 17'h00001,
		ACD_OP_ADD   = 17'h00002,
		ACD_OP_ADDI  = 17'h00004,
		ACD_OP_ADD_CARRY = 17'h00008,
		ACD_OP_ADD_OVF   = 17'h00010,
		ACD_OP_EQI   = 17'h00020,
		ACD_OP_EQ    = 17'h00040,
		ACD_OP_HS    = 17'h00080,
		ACD_OP_GE    = 17'h00100,
		ACD_OP_HI    = 17'h00200,
		ACD_OP_GT    = 17'h00400,
		ACD_OP_PZ    = 17'h00800,
		ACD_OP_PL    = 17'h01000,
		ACD_OP_STR   = 17'h02000,
		ACD_OP_DIVS  = 17'h04000,
		ACD_OP_MUL   = 17'h08000,
		ACD_OP_RSV   = 17'h10000
	} acd_op_e;

	// multiplier sequencer states
	typedef enum logic [1:0]
	{
		ACD_MS_IDLE = 2'h1,
		ACD_MS_BUSY = 2'h2
	} acd_mst_e;

endpackage

// >>> hdl/acd_regfile.sv
// sixteen entry general register file with registered read ports
`timescale 1ns/10ps
`include "acd_params.svh"

module acd_regfile
	import acd_pkg::*;
(
	input  wire logic           clk,
	input  wire logic           rst_b,
	input  wire logic [3:0]     rd_a_idx,
	input  wire logic [3:0]     rd_b_idx,
	input  wire acd_pkg::acd_wr_s wr,
	output logic [31:0]         rd_a_q,
	output logic [31:0]         rd_b_q,
	output logic [31:0]         r0_q
);
	logic [31:0] mem_q [16]; // register storage

	// storage write
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < 16; i++)
				mem_q[i] <= `ACD_ZERO32;
		end
		else if (wr.en)
			mem_q[wr.idx] <= wr.data;
	end

	// registered reads with write forwarding
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rd_a_q <= `ACD_ZERO32;
			rd_b_q <= `ACD_ZERO32;
			r0_q   <= `ACD_ZERO32;
		end
		else
		begin
			rd_a_q <= (wr.en && wr.idx == rd_a_idx) ? wr.data : mem_q[rd_a_idx];
			rd_b_q <= (wr.en && wr.idx == rd_b_idx) ? wr.data : mem_q[rd_b_idx];
			r0_q   <= (wr.en && wr.idx == `ACD_R0) ? wr.data : mem_q[`ACD_R0];
		end
	end
endmodule // acd_regfile
